// ==== rtl/nand_host_ctrl.sv ====
// host controller for the status, id, reset and ready/busy side of a nand flash
// assumes an ahb-lite master with single word transfers and pins synchronous to clock
//
// Contract
// [RULE_01] after status command 70h, each read cycle returns the status byte
// [RULE_02] device drives status after the later of chip select and read strobe falling
// [RULE_03] device refreshes status while strobes stay low
// [RULE_04] status-read mode lasts until another command is written
// [RULE_05] after status read mid random read, reissue 00h or 50h before reading on
// [RULE_06] status bit 0 is 0 on pass, 1 on fail
// [RULE_07] status bit 6 is 0 busy, 1 ready
// [RULE_08] status bit 7 is 0 protected, 1 not protected
// [RULE_09] id mode starts with command 90h then one address cycle 00h
// [RULE_10] id mode: first read gives maker code, second gives device code
// [RULE_11] id mode lasts until another command is written
// [RULE_12] command FFh triggers device reset
// [RULE_13] reset while busy aborts read, program or erase
// [RULE_14] reset clears command register; status becomes C0h with lock pin high
// [RULE_15] reset during reset is ignored
// [RULE_16] after reset command, busy line stays low for the reset busy time
// [RULE_17] power-up leaves main pointer mode; reset leaves device idle
// [RULE_18] busy line idles high, goes low for program, erase, random read
// [RULE_19] busy line is open drain, wired-or among devices
// [RULE_20] host waits at least 10 us after power-up before any command
// [RULE_21] host keeps lock pin low through power-up and power-down
// [RULE_22] program and erase need setup then confirm commands
// [RULE_23] status bits 1 to 5 read zero
// [RULE_24] spare read command moves pointer to spare; main read command returns it
//
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module nand_host_ctrl (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic             chip_select_low,
  output logic             command_latch,
  output logic             address_latch,
  output logic             write_strobe_n,
  output logic             output_strobe_n,
  output logic             lock_pin_n,
  input  wire logic [7:0]  io_in,
  output logic [7:0]       io_out,
  output logic             io_oe_n,
  input  wire logic        ready_busy_n
);
  ////////////////////////////////////////////////////////////////////////////////
  // step table: what each operation puts on the pins, one entry per index
  function automatic nand_host_pkg::step_t step_of(input logic [2:0] op, input logic [2:0] idx,
                                                   input logic [7:0] val, input logic [7:0] ptr);
    nand_host_pkg::step_t s;
    s.kind = nand_host_pkg::K_END;
    s.val  = val;
    case (op)
      nand_host_pkg::OP_WAIT: begin
        if (idx == 3'd0) s.kind = nand_host_pkg::K_WAIT;
      end
      nand_host_pkg::OP_STATUS: begin
        if (idx == 3'd0) begin
          s.kind = nand_host_pkg::K_CMD;
          s.val  = nand_host_pkg::CMD_STATUS;
        end else if (idx == 3'd1) s.kind = nand_host_pkg::K_READ;
      end
      nand_host_pkg::OP_ID: begin
        if (idx == 3'd0) begin
          s.kind = nand_host_pkg::K_CMD;
          s.val  = nand_host_pkg::CMD_ID;
        end else if (idx == 3'd1) begin
          s.kind = nand_host_pkg::K_ADDR;
          s.val  = nand_host_pkg::ID_ADDRESS;
        end else if (idx == 3'd2 || idx == 3'd3) s.kind = nand_host_pkg::K_READ;
      end
      nand_host_pkg::OP_RESET: begin
        if (idx == 3'd0) begin
          s.kind = nand_host_pkg::K_CMD;
          s.val  = nand_host_pkg::CMD_RESET;
        end else if (idx == 3'd1) s.kind = nand_host_pkg::K_WAIT;
      end
      nand_host_pkg::OP_CMD: begin
        if (idx == 3'd0) s.kind = nand_host_pkg::K_CMD;
        else if (idx == 3'd1 && is_busy_cmd(val)) s.kind = nand_host_pkg::K_WAIT;
      end
      nand_host_pkg::OP_ADDR: begin
        if (idx == 3'd0) s.kind = nand_host_pkg::K_ADDR;
      end
      nand_host_pkg::OP_DATA: begin
        if (idx == 3'd0) s.kind = nand_host_pkg::K_DATA;
      end
      nand_host_pkg::OP_READ: begin
        if (idx == 3'd0) begin
          s.kind = nand_host_pkg::K_CMD;
          s.val  = ptr;
        end else if (idx == 3'd1) s.kind = nand_host_pkg::K_READ;
      end
      default: s.kind = nand_host_pkg::K_END;
    endcase
    return s;
  endfunction

  function automatic logic is_confirm(input logic [7:0] c);
    return c == nand_host_pkg::CMD_PROG_CONF || c == nand_host_pkg::CMD_ERASE_CONF;
  endfunction

  function automatic logic is_setup(input logic [7:0] c);
    return c == nand_host_pkg::CMD_PROG_SETUP || c == nand_host_pkg::CMD_COPY_SETUP ||
           c == nand_host_pkg::CMD_ERASE_SETUP;
  endfunction

  // commands after which the device pulls the busy line low
  function automatic logic is_busy_cmd(input logic [7:0] c);
    return is_confirm(c) || c == nand_host_pkg::CMD_RESET;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, read data registered in the address phase
  logic        dph_valid, next_dph_valid;
  logic        dph_write, next_dph_write;
  logic [7:0]  dph_addr,  next_dph_addr;
  logic [31:0] order_reg, next_order_reg;
  logic        unlock,    next_unlock;
  logic [31:0] next_hrdata;
  logic [7:0]  status_byte, maker_byte, device_byte, data_byte;
  logic        refused;
  logic        powered;
  logic        status_mode;
  logic        spare_ptr;
  nand_host_pkg::seq_state_t state;

  always_comb begin
    next_dph_valid = hsel && hready && htrans[1];
    next_dph_write = hwrite;
    next_dph_addr  = haddr[7:0];
    next_order_reg = order_reg;
    next_unlock    = unlock;
    if (dph_valid && dph_write && dph_addr == nand_host_pkg::ADDR_ORDER) next_order_reg = hwdata;
    if (dph_valid && dph_write && dph_addr == nand_host_pkg::ADDR_CONFIG) begin
      next_unlock = hwdata[nand_host_pkg::CONFIG_UNLOCK];
    end
    next_hrdata = 32'h0000_0000;
    if (next_dph_valid && !hwrite) begin
      case (haddr[7:0])
        nand_host_pkg::ADDR_ORDER:  next_hrdata = next_order_reg;
        nand_host_pkg::ADDR_CONFIG: next_hrdata = {31'h0000_0000, next_unlock};
        nand_host_pkg::ADDR_STATE:  next_hrdata = {26'h000_0000, spare_ptr, status_mode, refused, powered,
                                                   ready_busy_n, state != nand_host_pkg::ST_IDLE};
        nand_host_pkg::ADDR_RESULT: next_hrdata = {data_byte, device_byte, maker_byte, status_byte};
        default:                    next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dph_valid <= 1'b0;
      dph_write <= 1'b0;
      dph_addr  <= 8'h00;
      order_reg <= nand_host_pkg::RESET_ORDER;
      unlock    <= nand_host_pkg::RESET_UNLOCK;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dph_valid <= next_dph_valid;
      dph_write <= next_dph_write;
      dph_addr  <= next_dph_addr;
      order_reg <= next_order_reg;
      unlock    <= next_unlock;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin sequencer
  logic        tick;
  logic        restart;
  logic        launch;
  logic        clear_refused;
  logic [2:0]  op, next_op;
  logic [2:0]  idx, next_idx;
  logic [7:0]  val, next_val;
  logic [10:0] wait_cnt, next_wait_cnt;
  logic        setup_pending, next_setup_pending;
  logic        next_refused, next_powered, next_status_mode, next_spare_ptr;
  logic [7:0]  next_status_byte, next_maker_byte, next_device_byte, next_data_byte;
  logic        next_cs_low, next_cle, next_ale, next_we_n, next_re_n, next_lock_n, next_oe_n;
  logic [7:0]  next_io_out;
  nand_host_pkg::seq_state_t next_state;
  nand_host_pkg::step_t      step;

  assign launch        = dph_valid && dph_write && dph_addr == nand_host_pkg::ADDR_ORDER;
  assign clear_refused = dph_valid && dph_write && dph_addr == nand_host_pkg::ADDR_STATE &&
                         hwdata[nand_host_pkg::STATE_REFUSED];
  assign restart       = state == nand_host_pkg::ST_NEXT;
  assign step          = step_of(op, idx, val, spare_ptr ? nand_host_pkg::CMD_READ_SPARE
                                                         : nand_host_pkg::CMD_READ_MAIN);

  nand_step_divider u_div (
    .clock   (clock),
    .rst     (rst),
    .restart (restart),
    .tick    (tick)
  );

  always_comb begin
    next_state = state;
    next_op = op;
    next_idx = idx;
    next_val = val;
    next_wait_cnt = wait_cnt;
    next_setup_pending = setup_pending;
    next_refused = refused;
    next_powered = powered;
    next_status_mode = status_mode;
    next_spare_ptr = spare_ptr;
    next_status_byte = status_byte;
    next_maker_byte = maker_byte;
    next_device_byte = device_byte;
    next_data_byte = data_byte;
    next_cs_low = chip_select_low;
    next_cle = command_latch;
    next_ale = address_latch;
    next_we_n = write_strobe_n;
    next_re_n = output_strobe_n;
    next_oe_n = io_oe_n;
    next_io_out = io_out;
    next_lock_n = powered && unlock;                                                 // [RULE_21]
    if (clear_refused) next_refused = 1'b0;
    case (state)
      nand_host_pkg::ST_POWER: begin
        next_wait_cnt = wait_cnt + 11'd1;
        if (wait_cnt == 11'(nand_host_pkg::POWERUP_CYCLES - 1)) begin                 // [RULE_20]
          next_powered = 1'b1;
          next_state   = nand_host_pkg::ST_IDLE;
        end
      end
      nand_host_pkg::ST_IDLE: begin
        if (launch) begin
          next_op  = hwdata[nand_host_pkg::ORDER_OP_LSB +: 3];
          next_val = hwdata[nand_host_pkg::ORDER_BYTE_LSB +: 8];
          next_idx = 3'd0;
          if (next_op == nand_host_pkg::OP_READ && !status_mode) next_idx = 3'd1;   // [RULE_05]
          if (next_op == nand_host_pkg::OP_CMD && is_confirm(next_val) && !setup_pending) begin
            next_refused = 1'b1;                                                      // [RULE_22]
          end else begin
            next_cs_low = 1'b1;
            next_state  = nand_host_pkg::ST_NEXT;
          end
        end
      end
      nand_host_pkg::ST_NEXT: begin
        next_cle    = step.kind == nand_host_pkg::K_CMD;
        next_ale    = step.kind == nand_host_pkg::K_ADDR;
        next_io_out = step.val;
        next_oe_n   = step.kind == nand_host_pkg::K_READ || step.kind == nand_host_pkg::K_WAIT ||
                      step.kind == nand_host_pkg::K_END;
        next_state  = nand_host_pkg::ST_SETUP;
        next_wait_cnt = 11'd0;
        if (step.kind == nand_host_pkg::K_END) begin
          next_cs_low = 1'b0;
          next_state  = nand_host_pkg::ST_IDLE;
        end else if (step.kind == nand_host_pkg::K_WAIT) begin
          next_state  = nand_host_pkg::ST_WAIT_WB;                                   // [RULE_16] [RULE_18]
        end else if (step.kind == nand_host_pkg::K_CMD) begin
          next_setup_pending = is_setup(step.val);                                   // [RULE_22]
          next_status_mode   = step.val == nand_host_pkg::CMD_STATUS || step.val == nand_host_pkg::CMD_ID;
          if (step.val == nand_host_pkg::CMD_READ_SPARE) next_spare_ptr = 1'b1;      // [RULE_24]
          if (step.val == nand_host_pkg::CMD_READ_MAIN || step.val == nand_host_pkg::CMD_READ_HALF) begin
            next_spare_ptr = 1'b0;                                                   // [RULE_24]
          end
          if (step.val == nand_host_pkg::CMD_RESET) next_spare_ptr = 1'b0;           // [RULE_12] [RULE_17]
        end
      end
      nand_host_pkg::ST_SETUP: begin
        if (tick) begin
          if (step.kind == nand_host_pkg::K_READ) next_re_n = 1'b0;
          else next_we_n = 1'b0;
          next_state = nand_host_pkg::ST_STROBE;
        end
      end
      nand_host_pkg::ST_STROBE: begin
        if (tick) begin
          next_we_n = 1'b1;
          next_re_n = 1'b1;
          if (step.kind == nand_host_pkg::K_READ) begin
            case (op)
              nand_host_pkg::OP_STATUS: next_status_byte = io_in;                    // [RULE_01]
              nand_host_pkg::OP_ID: begin
                if (idx == 3'd2) next_maker_byte = io_in;                            // [RULE_10]
                else next_device_byte = io_in;
              end
              default: next_data_byte = io_in;
            endcase
          end
          next_state = nand_host_pkg::ST_HOLD;
        end
      end
      nand_host_pkg::ST_HOLD: begin
        if (tick) begin
          next_cle   = 1'b0;
          next_ale   = 1'b0;
          next_oe_n  = 1'b1;
          next_idx   = idx + 3'd1;
          next_state = nand_host_pkg::ST_NEXT;
        end
      end
      nand_host_pkg::ST_WAIT_WB: begin
        next_wait_cnt = wait_cnt + 11'd1;
        if (wait_cnt == 11'(nand_host_pkg::WB_CYCLES - 1)) next_state = nand_host_pkg::ST_WAIT_RB;
      end
      nand_host_pkg::ST_WAIT_RB: begin
        if (ready_busy_n) begin                                                      // [RULE_19]
          next_idx   = idx + 3'd1;
          next_state = nand_host_pkg::ST_NEXT;
        end
      end
      default: next_state = nand_host_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state           <= nand_host_pkg::ST_POWER;
      op              <= nand_host_pkg::OP_WAIT;
      idx             <= 3'd0;
      val             <= 8'h00;
      wait_cnt        <= 11'd0;
      setup_pending   <= 1'b0;
      refused         <= 1'b0;
      powered         <= 1'b0;
      status_mode     <= 1'b0;
      spare_ptr       <= 1'b0;
      status_byte     <= 8'h00;
      maker_byte      <= 8'h00;
      device_byte     <= 8'h00;
      data_byte       <= 8'h00;
      chip_select_low <= 1'b0;
      command_latch   <= 1'b0;
      address_latch   <= 1'b0;
      write_strobe_n  <= 1'b1;
      output_strobe_n <= 1'b1;
      io_oe_n         <= 1'b1;
      io_out          <= 8'h00;
      lock_pin_n      <= 1'b0;
    end else begin
      state           <= next_state;
      op              <= next_op;
      idx             <= next_idx;
      val             <= next_val;
      wait_cnt        <= next_wait_cnt;
      setup_pending   <= next_setup_pending;
      refused         <= next_refused;
      powered         <= next_powered;
      status_mode     <= next_status_mode;
      spare_ptr       <= next_spare_ptr;
      status_byte     <= next_status_byte;
      maker_byte      <= next_maker_byte;
      device_byte     <= next_device_byte;
      data_byte       <= next_data_byte;
      chip_select_low <= next_cs_low;
      command_latch   <= next_cle;
      address_latch   <= next_ale;
      write_strobe_n  <= next_we_n;
      output_strobe_n <= next_re_n;
      io_oe_n         <= next_oe_n;
      io_out          <= next_io_out;
      lock_pin_n      <= next_lock_n;
    end
  end
endmodule
`default_nettype wire

// ==== inc/nand_host_pkg.sv ====
// constants, register map and types of the nand flash host controller
// assumes a single 125 MHz clock and a device answering on asynchronous strobes
package nand_host_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS   = 8;
  localparam int T_POWERUP_NS    = 10000;
  localparam int POWERUP_CYCLES  = (T_POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_STEP_NS       = 32;
  localparam int STEP_CYCLES     = (T_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_WB_NS         = 100;
  localparam int WB_CYCLES       = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // host register map (byte addresses)
  localparam logic [7:0] ADDR_ORDER  = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_STATE  = 8'h08;
  localparam logic [7:0] ADDR_RESULT = 8'h0C;

  // field positions
  localparam int ORDER_OP_LSB     = 0;
  localparam int ORDER_BYTE_LSB   = 8;
  localparam int CONFIG_UNLOCK    = 0;
  localparam int STATE_BUSY       = 0;
  localparam int STATE_RB         = 1;
  localparam int STATE_POWERED    = 2;
  localparam int STATE_REFUSED    = 3;
  localparam int STATE_STATUSMODE = 4;
  localparam int STATE_SPARE      = 5;

  // reset values
  localparam logic [31:0] RESET_ORDER  = 32'h0000_0000;
  localparam logic        RESET_UNLOCK = 1'b0;

  // device command codes
  localparam logic [7:0] CMD_READ_MAIN   = 8'h00;
  localparam logic [7:0] CMD_READ_HALF   = 8'h01;
  localparam logic [7:0] CMD_READ_SPARE  = 8'h50;
  localparam logic [7:0] CMD_STATUS      = 8'h70;
  localparam logic [7:0] CMD_ID          = 8'h90;
  localparam logic [7:0] CMD_RESET       = 8'hFF;
  localparam logic [7:0] CMD_PROG_SETUP  = 8'h80;
  localparam logic [7:0] CMD_COPY_SETUP  = 8'h8A;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_PROG_CONF   = 8'h10;
  localparam logic [7:0] CMD_ERASE_CONF  = 8'hD0;
  localparam logic [7:0] ID_ADDRESS      = 8'h00;

  // operations ordered through the order register
  localparam logic [2:0] OP_WAIT   = 3'h0;
  localparam logic [2:0] OP_STATUS = 3'h1;
  localparam logic [2:0] OP_ID     = 3'h2;
  localparam logic [2:0] OP_RESET  = 3'h3;
  localparam logic [2:0] OP_CMD    = 3'h4;
  localparam logic [2:0] OP_ADDR   = 3'h5;
  localparam logic [2:0] OP_DATA   = 3'h6;
  localparam logic [2:0] OP_READ   = 3'h7;

  typedef enum logic [2:0] {K_CMD, K_ADDR, K_DATA, K_READ, K_WAIT, K_END} step_kind_t;

  typedef struct packed {
    step_kind_t kind;
    logic [7:0] val;
  } step_t;

  typedef enum logic [2:0] {ST_POWER, ST_IDLE, ST_NEXT, ST_SETUP, ST_STROBE, ST_HOLD, ST_WAIT_WB,
                            ST_WAIT_RB} seq_state_t;

endpackage

// ==== rtl/nand_step_divider.sv ====
// divider giving one-cycle step enables for the pin sequencer
// assumes synchronous active-high reset; restart aligns the next tick
`timescale 1ns/1ps
`default_nettype none
module nand_step_divider (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic restart,
  output logic      tick
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic       next_tick;

  always_comb begin
    next_count = count + 8'h01;
    next_tick  = 1'b0;
    if (restart) begin
      next_count = 8'h00;
    end else if (count == 8'(nand_host_pkg::STEP_CYCLES - 1)) begin
      next_count = 8'h00;
      next_tick  = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      count <= 8'h00;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end
endmodule
`default_nettype wire

// ==== tb/nand_host_ctrl_sva.sv ====
// checker on host controller pins and bus answers
// assumes binding to nand_host_ctrl
`timescale 1ns/1ps
`default_nettype none
module nand_host_ctrl_sva (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       chip_select_low,
  input wire logic       command_latch,
  input wire logic       address_latch,
  input wire logic       write_strobe_n,
  input wire logic       output_strobe_n,
  input wire logic       lock_pin_n,
  input wire logic [7:0] io_out,
  input wire logic       io_oe_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // cycles since reset, saturating
  int pu_cnt;
  always_ff @(posedge clock) begin
    if (rst) pu_cnt <= 0;
    else if (pu_cnt < nand_host_pkg::POWERUP_CYCLES) pu_cnt <= pu_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////
  a_bus_okay:     assert property (hreadyout && !hresp) else $error("bus not okay");
  a_powerup_quiet: assert property (pu_cnt < nand_host_pkg::POWERUP_CYCLES |->
    !chip_select_low && !lock_pin_n) else $error("pins active in power-up");
  a_latch_excl:   assert property (!(command_latch && address_latch)) else $error("both latches high");
  a_strobe_excl:  assert property (!(!write_strobe_n && !output_strobe_n)) else $error("both strobes low");
  a_idle_quiet:   assert property (!chip_select_low |-> write_strobe_n && output_strobe_n)
    else $error("strobe while deselected");
  a_write_drives: assert property (!write_strobe_n |-> !io_oe_n && $stable(io_out))
    else $error("write data unsteady");
  a_read_release: assert property (!output_strobe_n |-> io_oe_n)
    else $error("io driven in read");
  a_we_pulse:     assert property ($fell(write_strobe_n) |-> !write_strobe_n [*4] ##1 write_strobe_n)
    else $error("strobe width");
endmodule
bind nand_host_ctrl nand_host_ctrl_sva u_sva (.clock, .rst, .hreadyout, .hresp, .chip_select_low, .command_latch,
  .address_latch, .write_strobe_n, .output_strobe_n, .lock_pin_n, .io_out, .io_oe_n);
`default_nettype wire

// ==== tb/nand_flash_model.sv ====
// nand flash model: status, id, reset, busy, pointers
// assumes chip_select_low high means selected
`timescale 1ns/1ps
`default_nettype none
module nand_flash_model #(
  parameter logic [7:0] MAKER    = 8'h5A,  // arbitrary code
  parameter logic [7:0] DEVICE   = 8'hC3,  // arbitrary code
  parameter int         BUSY_CYC = 60,
  parameter int         RST_CYC  = 30
) (
  input  wire logic       clock,
  input  wire logic       chip_select_low,
  input  wire logic       command_latch,
  input  wire logic       address_latch,
  input  wire logic       write_strobe_n,
  input  wire logic       output_strobe_n,
  input  wire logic       lock_pin_n,
  input  wire logic       io_oe_n,
  input  wire logic       fail_next,
  input  wire logic [7:0] io_out,
  output logic      [7:0] io_in,
  output logic            ready_busy_n
);
  // modes: 0 idle, 1 main, 2 spare, 3 status, 4 id, 5 id address pending
  logic [2:0] mode = 3'h1;
  logic setup = 1'b0, pf = 1'b0, in_rst = 1'b0, id_idx = 1'b0, busy = 1'b0;
  time busy_end = 0;
  logic [7:0] dev_byte;
  always @(posedge clock) busy <= ($time < busy_end);
  assign ready_busy_n = ~busy; // pulled low while busy
  always @(posedge write_strobe_n) if (chip_select_low) begin
    if (command_latch && !(in_rst && busy && io_out == 8'hFF)) begin
      case (io_out)
        8'h70: mode = 3'h3;
        8'h90: mode = 3'h5;
        8'h00: mode = 3'h1;
        8'h50: mode = 3'h2;
        8'hFF: begin
          mode = 3'h0;
          setup = 1'b0;
          pf = 1'b0;
          in_rst = 1'b1;
          busy_end = $time + RST_CYC * 8;
        end
        8'h80, 8'h8A, 8'h60: setup = 1'b1;
        8'h10, 8'hD0: if (setup) begin
          setup = 1'b0;
          pf = fail_next;
          in_rst = 1'b0;
          busy_end = $time + BUSY_CYC * 8;
        end
        default: ;
      endcase
    end else if (address_latch && mode == 3'h5 && io_out == 8'h00) begin
      mode = 3'h4;
      id_idx = 1'b0;
    end
  end
  always @(posedge output_strobe_n) if (mode == 3'h4) id_idx = 1'b1;
  // live status
  assign dev_byte = mode == 3'h3 ? {lock_pin_n, ~busy, 5'h00, pf} : mode == 3'h4 ? (id_idx ? DEVICE : MAKER) :
                    mode == 3'h1 ? 8'h3A : mode == 3'h2 ? 8'h5C : 8'h00;
  // undriven bus shows the inverse
  assign io_in = !io_oe_n ? io_out : (chip_select_low && !output_strobe_n) ? dev_byte : ~dev_byte;
endmodule
`default_nettype wire

// ==== tb/nand_status_id_reset_control_tb_top.sv ====
// bench: ahb-lite master, flash model, checker
// assumes 125 MHz clock, sync high reset
`timescale 1ns/1ps
`default_nettype none
module nand_status_id_reset_control_tb_top;
  logic clock = 1'b0, rst = 1'b1, hwrite = 1'b0, fail_next = 1'b0, f;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = '0, hwdata = '0, rd, hrdata;
  logic hreadyout, hresp, csl, cle, ale, we_n, re_n, lock_n, oe_n, rb_n;
  logic [7:0] io_in, io_out;
  int n_mismatch = 0, n_tests = 0, rb_falls = 0, k;
  initial forever #4 clock = ~clock;
  always @(negedge rb_n) rb_falls++;
  nand_host_ctrl u_dut (.clock, .rst, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .chip_select_low(csl), .command_latch(cle),
    .address_latch(ale), .write_strobe_n(we_n), .output_strobe_n(re_n), .lock_pin_n(lock_n), .io_in, .io_out,
    .io_oe_n(oe_n), .ready_busy_n(rb_n));
  nand_flash_model u_flash (.clock, .chip_select_low(csl), .command_latch(cle), .address_latch(ale),
    .write_strobe_n(we_n), .output_strobe_n(re_n), .lock_pin_n(lock_n), .io_oe_n(oe_n), .fail_next, .io_out,
    .io_in, .ready_busy_n(rb_n));
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic order(input logic [2:0] op, input logic [7:0] b);
    bus(1'b1, nand_host_pkg::ADDR_ORDER, {16'h0000, b, 5'h00, op});
    for (k = 0; k < 400; k++) begin
      bus(1'b0, nand_host_pkg::ADDR_STATE, '0);
      if (rd[nand_host_pkg::STATE_BUSY] === 1'b0) break;
    end
  endtask
  task automatic result(input logic [2:0] op, input logic [7:0] b);
    order(op, b);
    bus(1'b0, nand_host_pkg::ADDR_RESULT, '0);
  endtask
  function automatic logic [7:0] stat(input logic lk, input logic fl);
    return {lk, 1'b1, 5'h00, fl};
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    #(8 * 60000);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'habd5));
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    bus(1'b0, nand_host_pkg::ADDR_CONFIG, '0);
    chk("config", 32'h00000000, rd);
    for (int i = 0; i < 1000; i++) begin
      bus(1'b0, nand_host_pkg::ADDR_STATE, '0);
      if (rd[nand_host_pkg::STATE_POWERED] === 1'b1) break;
    end
    order(nand_host_pkg::OP_CMD, nand_host_pkg::CMD_PROG_CONF);
    chk("refused", 1'b1, rd[nand_host_pkg::STATE_REFUSED]);
    chk("no busy", 0, rb_falls);
    bus(1'b1, nand_host_pkg::ADDR_STATE, 32'h00000008);
    bus(1'b0, nand_host_pkg::ADDR_STATE, '0);
    chk("cleared", 1'b0, rd[nand_host_pkg::STATE_REFUSED]);
    result(nand_host_pkg::OP_STATUS, 8'h00);
    chk("locked", 8'h40, rd[7:0]);
    result(nand_host_pkg::OP_ID, 8'h00);
    chk("id", {8'hC3, 8'h5A}, rd[23:8]);
    bus(1'b1, nand_host_pkg::ADDR_CONFIG, 32'h00000001);
    for (int i = 0; i < 6; i++) begin
      f = 1'($urandom % 2);
      fail_next <= f;
      order(nand_host_pkg::OP_CMD, i[0] ? nand_host_pkg::CMD_ERASE_SETUP : nand_host_pkg::CMD_PROG_SETUP);
      order(nand_host_pkg::OP_ADDR, 8'($urandom));
      if (!i[0]) order(nand_host_pkg::OP_DATA, 8'($urandom));
      order(nand_host_pkg::OP_CMD, i[0] ? nand_host_pkg::CMD_ERASE_CONF : nand_host_pkg::CMD_PROG_CONF);
      chk("busy seen", i + 1, rb_falls);
      result(nand_host_pkg::OP_STATUS, 8'h00);
      chk("status", stat(1'b1, f), rd[7:0]);
    end
    result(nand_host_pkg::OP_READ, 8'h00);
    chk("main read", 8'h3A, rd[31:24]);
    order(nand_host_pkg::OP_CMD, nand_host_pkg::CMD_READ_SPARE);
    result(nand_host_pkg::OP_STATUS, 8'h00);
    result(nand_host_pkg::OP_READ, 8'h00);
    chk("spare read", 8'h5C, rd[31:24]);
    fail_next <= 1'b1;
    order(nand_host_pkg::OP_CMD, nand_host_pkg::CMD_ERASE_SETUP);
    order(nand_host_pkg::OP_CMD, nand_host_pkg::CMD_ERASE_CONF);
    order(nand_host_pkg::OP_RESET, 8'h00);
    chk("reset busy", 8, rb_falls);
    result(nand_host_pkg::OP_STATUS, 8'h00);
    chk("after reset", 8'hC0, rd[7:0]);
    bus(1'b0, 8'h10, '0);
    chk("unmapped", 32'h00000000, rd);
    give_verdict();
  end
endmodule
`default_nettype wire
